// ===== tmr_pkg.sv
// constants shared by the 16-bit timer, its prescaler and its tick source
// assumes byte-wide registers reached over a plain strobe port
package tmr_pkg;
	// byte addresses of the registers
	localparam logic [7:0] ADDR_INTCTL = 8'h0B;
	localparam logic [7:0] ADDR_FLAGS = 8'h0C;
	localparam logic [7:0] ADDR_CNT_LO = 8'h0E;
	localparam logic [7:0] ADDR_CNT_HI = 8'h0F;
	localparam logic [7:0] ADDR_CTL = 8'h10;
	localparam logic [7:0] ADDR_IRQEN = 8'h8C;
	// timer control fields
	localparam int CTL_W = 6;
	localparam int CTL_RUN = 0;
	localparam int CTL_CSEL = 1;
	localparam int CTL_SYNCB = 2;
	localparam int CTL_OSCEN = 3;
	localparam int CTL_PSEL = 4;
	localparam logic [5:0] CTL_RESET = 6'h00;
	// flag and enable bits
	localparam int FLAG_W = 2;
	localparam int FLAG_OVF = 0;
	localparam int FLAG_TRIG = 1;
	localparam logic [1:0] FLAGS_RESET = 2'h0;
	localparam logic [1:0] IRQEN_RESET = 2'h0;
	localparam logic [7:0] INTCTL_RESET = 8'h00;
	// compare unit mode code for the special event trigger
	localparam logic [3:0] MODE_SPECIAL_TRIG = 4'hB;
	// counter limits
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// instruction clock is the system clock divided by four
	localparam int INSTR_DIV = 4;
	localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIV - 1);
	localparam logic [1:0] PSEL_DIV1 = 2'h0;
	localparam logic [1:0] PSEL_DIV2 = 2'h1;
	localparam logic [1:0] PSEL_DIV4 = 2'h2;
	localparam logic [2:0] PRE_MASK_DIV1 = 3'h0;
	localparam logic [2:0] PRE_MASK_DIV2 = 3'h1;
	localparam logic [2:0] PRE_MASK_DIV4 = 3'h3;
	localparam logic [2:0] PRE_MASK_DIV8 = 3'h7;
endpackage

// ===== tmr_tick_src.sv
// count clock source: instruction clock enable or external pin rising edge
// assumes the external pin is already synchronous to sys_clk
`timescale 1ns/1ps
module tmr_tick_src (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clkSel,
	input wire logic extClkPin,
	output logic tick
);
	typedef struct packed {
		logic [1:0] div;
		logic extPrev;
		logic tick;
	} tmr_src_state_t;
	tmr_src_state_t st_r;
	tmr_src_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.div = 2'(st_r.div + 2'h1);
		st_nxt.extPrev = extClkPin;
		st_nxt.tick = clkSel ? (extClkPin & ~st_r.extPrev) : (st_r.div == tmr_pkg::INSTR_DIV_LAST);
		if (!nrst) begin
			st_nxt = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		st_r <= st_nxt;
	end

	assign tick = st_r.tick;

	instr_rate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!clkSel && $past(!clkSel) && st_r.div == tmr_pkg::INSTR_DIV_LAST) |=> tick)
		else $error("instruction clock tick missing");
endmodule

// ===== tmr_prescaler.sv
// 1:1 to 1:8 prescaler between the clock source and the 16-bit counter
// assumes tickIn is a one-cycle enable and clear wins over it
`timescale 1ns/1ps
module tmr_prescaler (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic [1:0] sel,
	input wire logic tickIn,
	output logic tickOut
);
	typedef struct packed {
		logic [2:0] cnt;
		logic tickOut;
	} tmr_pre_state_t;
	tmr_pre_state_t st_r;
	tmr_pre_state_t st_nxt;
	logic [2:0] mask;

	always_comb begin
		case (sel)
			tmr_pkg::PSEL_DIV1: mask = tmr_pkg::PRE_MASK_DIV1;
			tmr_pkg::PSEL_DIV2: mask = tmr_pkg::PRE_MASK_DIV2;
			tmr_pkg::PSEL_DIV4: mask = tmr_pkg::PRE_MASK_DIV4;
			default: mask = tmr_pkg::PRE_MASK_DIV8;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.tickOut = 1'b0;
		if (clear) begin
			st_nxt.cnt = 3'h0;
		end else if (tickIn) begin
			if ((st_r.cnt & mask) == mask) begin
				st_nxt.cnt = 3'h0;
				st_nxt.tickOut = 1'b1;
			end else begin
				st_nxt.cnt = 3'(st_r.cnt + 3'h1);
			end
		end
		if (!nrst) begin
			st_nxt = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		st_r <= st_nxt;
	end

	assign tickOut = st_r.tickOut;

	presc_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		clear |=> (st_r.cnt == 3'h0) && !tickOut)
		else $error("prescaler not cleared by count write");
	presc_divide_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		tickOut |-> $past(tickIn) && (($past(st_r.cnt) & $past(mask)) == $past(mask)))
		else $error("prescaler fired off its ratio");
endmodule

// ===== tmr_timer16.sv
// 16-bit timer with prescaler, special event trigger reset and its registers
// assumes compare units give a one-cycle match pulse with their mode field
// and that porBorReset is high for power-on and brown-out resets only
//
// What this block does
// - compare-mode special trigger from either unit clears count
// - trigger clear never sets the overflow flag
// - trigger clear not honoured in asynchronous counting
// - same-cycle count write beats the trigger
// - compare pair acts as the counter period
// - count bytes survive every reset
// - power-on/brown-out clears control; other resets keep it
// - writing either count byte clears the prescaler
// - low count byte at its own address
// - high count byte at the next address
// - unimplemented bits read as zero
// - count wraps FFFFh to 0000h, setting overflow flag
// - prescale select divides by 1, 2, 4, 8
// - clock source: instruction clock or external rising edge
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module tmr_timer16 (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic porBorReset,
	input wire logic [7:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [7:0] rdData,
	input wire logic extClkPin,
	input wire logic [3:0] compareModeA,
	input wire logic compareMatchA,
	input wire logic [3:0] compareModeB,
	input wire logic compareMatchB,
	output logic irq
);
	typedef struct packed {
		logic [15:0] count;
		logic [5:0] ctl;
		logic [7:0] intCtl;
		logic [1:0] flags;
		logic [1:0] irqEn;
		logic [7:0] rdData;
		logic irq;
		// checker-only marker: count has been loaded since power-on
		logic cntValid;
	} tmr_main_state_t;

	tmr_main_state_t st_r;
	tmr_main_state_t st_nxt;
	logic srcTick;
	logic countTick;
	logic anyReset;
	logic wrLo;
	logic wrHi;
	logic countWrite;
	logic asyncMode;
	logic trigValid;
	logic incr;
	logic ovfSet;
	logic trigSet;

	function automatic logic isTrig(input logic [3:0] mode, input logic match);
		isTrig = match && (mode == tmr_pkg::MODE_SPECIAL_TRIG);
	endfunction

	tmr_tick_src u_src (
		.sys_clk(sys_clk),
		.nrst(nrst && !porBorReset),
		.clkSel(st_r.ctl[tmr_pkg::CTL_CSEL]),
		.extClkPin(extClkPin),
		.tick(srcTick)
	);

	tmr_prescaler u_pre (
		.sys_clk(sys_clk),
		.nrst(nrst && !porBorReset),
		.clear(countWrite),
		.sel(st_r.ctl[tmr_pkg::CTL_PSEL +: 2]),
		.tickIn(srcTick & st_r.ctl[tmr_pkg::CTL_RUN]),
		.tickOut(countTick)
	);

	always_comb begin
		anyReset = !nrst || porBorReset;
		wrLo = wrEn && (addr == tmr_pkg::ADDR_CNT_LO);
		wrHi = wrEn && (addr == tmr_pkg::ADDR_CNT_HI);
		countWrite = wrLo || wrHi;
		// async counting cannot be cleared cleanly, so the trigger is dropped there
		asyncMode = st_r.ctl[tmr_pkg::CTL_CSEL] && st_r.ctl[tmr_pkg::CTL_SYNCB];
		trigValid = (isTrig(compareModeA, compareMatchA) || isTrig(compareModeB, compareMatchB))
			&& !asyncMode;
		incr = countTick && st_r.ctl[tmr_pkg::CTL_RUN];
		ovfSet = incr && !countWrite && !trigValid && (st_r.count == tmr_pkg::CNT_MAX);
		trigSet = trigValid && !countWrite;
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdData = 8'h00;
		// count update: write, then trigger, then increment
		if (countWrite) begin
			if (wrLo) begin
				st_nxt.count[7:0] = wrData;
			end
			if (wrHi) begin
				st_nxt.count[15:8] = wrData;
			end
		end else if (trigValid) begin
			st_nxt.count = tmr_pkg::CNT_ZERO;
		end else if (incr) begin
			st_nxt.count = 16'(st_r.count + 16'h0001);
		end
		st_nxt.cntValid = st_r.cntValid | countWrite | trigValid;
		// other registers
		if (wrEn) begin
			case (addr)
				tmr_pkg::ADDR_CTL: begin
					st_nxt.ctl = wrData[5:0];
				end
				tmr_pkg::ADDR_INTCTL: begin
					st_nxt.intCtl = wrData;
				end
				tmr_pkg::ADDR_IRQEN: begin
					st_nxt.irqEn = wrData[1:0];
				end
				tmr_pkg::ADDR_FLAGS: begin
					st_nxt.flags = st_r.flags & ~wrData[1:0];
				end
				default: begin
				end
			endcase
		end
		// hardware set wins over a same-cycle clear
		st_nxt.flags[tmr_pkg::FLAG_OVF] = st_nxt.flags[tmr_pkg::FLAG_OVF] | ovfSet;
		st_nxt.flags[tmr_pkg::FLAG_TRIG] = st_nxt.flags[tmr_pkg::FLAG_TRIG] | trigSet;
		if (rdEn) begin
			case (addr)
				tmr_pkg::ADDR_CNT_LO: begin
					st_nxt.rdData = st_r.count[7:0];
				end
				tmr_pkg::ADDR_CNT_HI: begin
					st_nxt.rdData = st_r.count[15:8];
				end
				tmr_pkg::ADDR_CTL: begin
					st_nxt.rdData = {2'b00, st_r.ctl};
				end
				tmr_pkg::ADDR_INTCTL: begin
					st_nxt.rdData = st_r.intCtl;
				end
				tmr_pkg::ADDR_FLAGS: begin
					st_nxt.rdData = {6'h00, st_r.flags};
				end
				tmr_pkg::ADDR_IRQEN: begin
					st_nxt.rdData = {6'h00, st_r.irqEn};
				end
				default: begin
					st_nxt.rdData = 8'h00;
				end
			endcase
		end
		st_nxt.irq = |(st_nxt.flags & st_nxt.irqEn);
		if (anyReset) begin
			// count is never touched by a reset; it powers up unknown
			st_nxt.count = st_r.count;
			st_nxt.cntValid = porBorReset ? 1'b0 : st_r.cntValid;
			st_nxt.ctl = porBorReset ? tmr_pkg::CTL_RESET : st_r.ctl;
			st_nxt.intCtl = tmr_pkg::INTCTL_RESET;
			st_nxt.flags = tmr_pkg::FLAGS_RESET;
			st_nxt.irqEn = tmr_pkg::IRQEN_RESET;
			st_nxt.rdData = 8'h00;
			st_nxt.irq = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		st_r <= st_nxt;
	end

	assign rdData = st_r.rdData;
	assign irq = st_r.irq;

	trig_clears_a: assert property (@(posedge sys_clk) disable iff (anyReset)
		(trigValid && !countWrite) |=> (st_r.count == tmr_pkg::CNT_ZERO))
		else $error("special trigger did not clear count");

	trig_noflag_a: assert property (@(posedge sys_clk) disable iff (anyReset)
		(trigValid && !st_r.flags[tmr_pkg::FLAG_OVF]) |=> !st_r.flags[tmr_pkg::FLAG_OVF])
		else $error("trigger clear raised overflow flag");

	async_ignore_a: assert property (@(posedge sys_clk) disable iff (anyReset)
		(st_r.cntValid && asyncMode && !countWrite && !incr)
		|=> (st_r.count == $past(st_r.count)))
		else $error("count moved in async mode without a tick");

	write_wins_a: assert property (@(posedge sys_clk) disable iff (anyReset)
		(wrLo && (compareMatchA || compareMatchB)) |=> (st_r.count[7:0] == $past(wrData)))
		else $error("trigger beat a count write");

	period_wrap_a: assert property (@(posedge sys_clk) disable iff (anyReset)
		(trigValid && !countWrite) ##1 (!countWrite && !trigValid && incr)
		|=> (st_r.count == 16'h0001))
		else $error("count did not restart from zero after trigger");

	keep_count_a: assert property (@(posedge sys_clk) disable iff (1'b0)
		(anyReset && st_r.cntValid) |=> (st_r.count == $past(st_r.count)))
		else $error("reset changed the count");

	por_clear_a: assert property (@(posedge sys_clk) disable iff (1'b0)
		porBorReset |=> (st_r.ctl == tmr_pkg::CTL_RESET))
		else $error("power-on reset left control set");

	other_keep_a: assert property (@(posedge sys_clk) disable iff (1'b0)
		(!nrst && !porBorReset) |=> (st_r.ctl == $past(st_r.ctl)))
		else $error("ordinary reset changed control");

	read_bytes_a: assert property (@(posedge sys_clk) disable iff (anyReset)
		(rdEn && (addr == tmr_pkg::ADDR_CNT_HI)) |=> (rdData == $past(st_r.count[15:8])))
		else $error("high count byte read wrong");

	read_zero_a: assert property (@(posedge sys_clk) disable iff (anyReset)
		(rdEn && (addr == tmr_pkg::ADDR_CTL)) |=> (rdData[7:6] == 2'b00))
		else $error("unimplemented control bits read non-zero");

	wrap_flag_a: assert property (@(posedge sys_clk) disable iff (anyReset)
		ovfSet |=> (st_r.count == tmr_pkg::CNT_ZERO) && st_r.flags[tmr_pkg::FLAG_OVF]
		&& (irq || !st_r.irqEn[tmr_pkg::FLAG_OVF]))
		else $error("wrap did not set overflow flag");

	run_stop_a: assert property (@(posedge sys_clk) disable iff (anyReset)
		(st_r.cntValid && !st_r.ctl[tmr_pkg::CTL_RUN] && !countWrite && !trigValid)
		|=> (st_r.count == $past(st_r.count)))
		else $error("counter moved while stopped");

	irq_level_a: assert property (@(posedge sys_clk) disable iff (anyReset)
		irq == |(st_r.flags & st_r.irqEn))
		else $error("interrupt without unmasked flag");
endmodule

// ===== tmr_cmp_model.sv
// behavioural compare unit: mode field and a one-cycle match pulse
// assumes fire is driven by non-blocking assignment just after a rising edge
`timescale 1ns/1ps
module tmr_cmp_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic fire,
	input wire logic [3:0] modeIn,
	output logic [3:0] compareMode,
	output logic compareMatch
);
	// registered like a real comparator, so the match lands a cycle after fire
	always_ff @(posedge sys_clk) begin
		compareMode <= nrst ? modeIn : 4'h0;
		compareMatch <= nrst & fire;
	end
endmodule

// ===== tmr_tb.sv
// self-checking bench for tmr_timer16 over its strobe register port
// assumes two tmr_cmp_model instances stand in for the compare units
`timescale 1ns/1ps
module testbench;
	logic sys_clk, nrst, porBorReset, wrEn, rdEn, extClkPin, fireA, fireB, irq;
	logic cmpMatchA, cmpMatchB;
	logic [7:0] addr, wrData, rdData, d, e;
	logic [3:0] modeA, modeB, cmpModeA, cmpModeB;
	logic [15:0] c;
	int miscompares, samplesChecked;
	tmr_timer16 dut (.sys_clk(sys_clk), .nrst(nrst), .porBorReset(porBorReset), .addr(addr),
		.wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .extClkPin(extClkPin),
		.compareModeA(cmpModeA), .compareMatchA(cmpMatchA), .compareModeB(cmpModeB),
		.compareMatchB(cmpMatchB), .irq(irq));
	tmr_cmp_model unitA (.sys_clk(sys_clk), .nrst(nrst), .fire(fireA), .modeIn(modeA),
		.compareMode(cmpModeA), .compareMatch(cmpMatchA));
	tmr_cmp_model unitB (.sys_clk(sys_clk), .nrst(nrst), .fire(fireB), .modeIn(modeB),
		.compareMode(cmpModeB), .compareMatch(cmpMatchB));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic endSim();
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// the write strobe stays up for back-to-back calls; rd and cyc drop it
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		addr <= a;
		wrData <= v;
		wrEn <= 1'b1;
		rdEn <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		addr <= a;
		rdEn <= 1'b1;
		wrEn <= 1'b0;
		@(posedge sys_clk);
		rdEn <= 1'b0;
		// sample mid-cycle, clear of the launching edge
		@(negedge sys_clk);
		v = rdData;
		@(posedge sys_clk);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk({8'h00, v}, {8'h00, exp});
	endtask
	task automatic wrCnt(input logic [15:0] v);
		wr(tmr_pkg::ADDR_CNT_LO, v[7:0]);
		wr(tmr_pkg::ADDR_CNT_HI, v[15:8]);
	endtask
	task automatic cyc(input int n);
		wrEn <= 1'b0;
		rdEn <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic trig(input bit b);
		if (b) fireB <= 1'b1;
		else fireA <= 1'b1;
		@(posedge sys_clk);
		fireA <= 1'b0;
		fireB <= 1'b0;
	endtask
	task automatic ext(input int n);
		cyc(0);
		repeat (n) begin
			extClkPin <= 1'b1;
			repeat (2) @(posedge sys_clk);
			extClkPin <= 1'b0;
			repeat (2) @(posedge sys_clk);
		end
	endtask
	task automatic rstPulse(input logic por);
		cyc(0);
		nrst <= por;
		porBorReset <= por;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		porBorReset <= 1'b0;
		@(posedge sys_clk);
	endtask
	// a hang here counts as a mismatch and ends the run
	task automatic waitIrq(input logic v);
		cyc(0);
		for (int n = 0; irq !== v; n++) begin
			if (n == 50) begin
				miscompares++;
				endSim();
			end
			@(posedge sys_clk);
		end
	endtask
	initial begin
		miscompares = 0;
		samplesChecked = 0;
		nrst = 1'b0;
		porBorReset = 1'b1;
		{addr, wrData, wrEn, rdEn, extClkPin, fireA, fireB} = '0;
		modeA = tmr_pkg::MODE_SPECIAL_TRIG;
		modeB = tmr_pkg::MODE_SPECIAL_TRIG;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		porBorReset <= 1'b0;
		@(posedge sys_clk);
		rdChk(tmr_pkg::ADDR_CTL, 8'h00);
		rdChk(tmr_pkg::ADDR_FLAGS, 8'h00);
		rdChk(tmr_pkg::ADDR_IRQEN, 8'h00);
		rdChk(tmr_pkg::ADDR_INTCTL, 8'h00);
		wr(tmr_pkg::ADDR_INTCTL, 8'hA5);
		wr(8'h20, 8'h5A);
		wr(tmr_pkg::ADDR_IRQEN, 8'hFF);
		rdChk(tmr_pkg::ADDR_INTCTL, 8'hA5);
		rdChk(8'h20, 8'h00);
		rdChk(tmr_pkg::ADDR_IRQEN, 8'h03);
		wr(tmr_pkg::ADDR_IRQEN, 8'h00);
		wr(tmr_pkg::ADDR_CTL, 8'hFF);
		rdChk(tmr_pkg::ADDR_CTL, 8'h3F);
		// async mode with a still pin, so the count holds
		wrCnt(16'h1234);
		rdChk(tmr_pkg::ADDR_CNT_LO, 8'h34);
		rdChk(tmr_pkg::ADDR_CNT_HI, 8'h12);
		rstPulse(1'b0);
		rdChk(tmr_pkg::ADDR_CTL, 8'h3F);
		rdChk(tmr_pkg::ADDR_CNT_LO, 8'h34);
		rstPulse(1'b1);
		rdChk(tmr_pkg::ADDR_CTL, 8'h00);
		rdChk(tmr_pkg::ADDR_CNT_HI, 8'h12);
		// bit 1 picks the unit, bit 0 a wrong mode code
		for (int i = 0; i < 4; i++) begin
			modeA <= i[0] ? 4'hA : tmr_pkg::MODE_SPECIAL_TRIG;
			modeB <= i[0] ? 4'hA : tmr_pkg::MODE_SPECIAL_TRIG;
			wrCnt(16'hFFFF);
			wr(tmr_pkg::ADDR_FLAGS, 8'h03);
			cyc(2);
			trig(i[1]);
			cyc(2);
			rd(tmr_pkg::ADDR_CNT_LO, c[7:0]);
			rd(tmr_pkg::ADDR_CNT_HI, c[15:8]);
			chk(c, i[0] ? 16'hFFFF : 16'h0000);
			rdChk(tmr_pkg::ADDR_FLAGS, i[0] ? 8'h00 : 8'h02);
		end
		// the last pass left both units on the wrong code
		modeA <= tmr_pkg::MODE_SPECIAL_TRIG;
		modeB <= tmr_pkg::MODE_SPECIAL_TRIG;
		wr(tmr_pkg::ADDR_CTL, 8'h06);
		wrCnt(16'hFFFF);
		cyc(1);
		trig(1'b0);
		cyc(2);
		rdChk(tmr_pkg::ADDR_CNT_LO, 8'hFF);
		wr(tmr_pkg::ADDR_CTL, 8'h00);
		wr(tmr_pkg::ADDR_FLAGS, 8'h03);
		cyc(1);
		trig(1'b0);
		wr(tmr_pkg::ADDR_CNT_LO, 8'h55);
		cyc(2);
		rdChk(tmr_pkg::ADDR_CNT_LO, 8'h55);
		rdChk(tmr_pkg::ADDR_CNT_HI, 8'hFF);
		rdChk(tmr_pkg::ADDR_FLAGS, 8'h00);
		wrCnt(16'hFFFE);
		wr(tmr_pkg::ADDR_IRQEN, 8'h01);
		wr(tmr_pkg::ADDR_CTL, 8'h01);
		waitIrq(1'b1);
		wr(tmr_pkg::ADDR_CTL, 8'h00);
		rdChk(tmr_pkg::ADDR_CNT_HI, 8'h00);
		rdChk(tmr_pkg::ADDR_FLAGS, 8'h01);
		wr(tmr_pkg::ADDR_IRQEN, 8'h00);
		waitIrq(1'b0);
		wr(tmr_pkg::ADDR_IRQEN, 8'h01);
		waitIrq(1'b1);
		wr(tmr_pkg::ADDR_FLAGS, 8'h01);
		waitIrq(1'b0);
		// 257 run cycles give 64 source ticks, give or take the divider phase
		for (int p = 0; p < 4; p++) begin
			e = 8'h40 >> p;
			wr(tmr_pkg::ADDR_CTL, 8'(p << 4));
			wrCnt(16'h0000);
			wr(tmr_pkg::ADDR_CTL, 8'(p << 4) | 8'h01);
			cyc(256);
			wr(tmr_pkg::ADDR_CTL, 8'(p << 4));
			rd(tmr_pkg::ADDR_CNT_LO, d);
			chk(16'(d + 8'h01 >= e && d <= e + 8'h01), 16'h0001);
			cyc(40);
			rdChk(tmr_pkg::ADDR_CNT_LO, d);
		end
		wr(tmr_pkg::ADDR_CTL, 8'h03);
		wrCnt(16'h0000);
		ext(5);
		rdChk(tmr_pkg::ADDR_CNT_LO, 8'h05);
		trig(1'b1);
		ext(2);
		rdChk(tmr_pkg::ADDR_CNT_LO, 8'h02);
		wr(tmr_pkg::ADDR_CTL, 8'h33);
		wrCnt(16'h0000);
		ext(7);
		wr(tmr_pkg::ADDR_CNT_HI, 8'h00);
		ext(7);
		rdChk(tmr_pkg::ADDR_CNT_LO, 8'h00);
		ext(1);
		rdChk(tmr_pkg::ADDR_CNT_LO, 8'h01);
		endSim();
	end
endmodule
